// ===== hdl/wwd_regs.svh
// Register offsets, reset values and timing counts of the window watchdog
// Notes on behaviour
// - Activation bit set by write, cleared by reset
// - Reset request only while activation bit set or hardware option on
// - Control bits 6:0 are live downcounter
// - Decrement once per 12288 clocks, free prescaler
// - Active and count 0x40 to 0x3F: reset
// - Hardware option forces watchdog always active
// - Window bits 6:0 limit, bit 7 zero
// - Reset: window 0x7F, control 0x7F
// - Active reload above window limit: reset
// - Counter decrements even while disabled
// - Halt-reset option: halt request while active gives reset
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH
// ---------------------------------------------------------------
// Offsets (byte addresses, index times four)
// ---------------------------------------------------------------
`define WWD_CTRL_IDX      8'h00
`define WWD_WIN_IDX       8'h01
`define WWD_CTRL_ADDR     8'h00
`define WWD_WIN_ADDR      8'h04
// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define WWD_ACT_BIT       7
`define WWD_TOP_BIT       6
`define WWD_CNT_RST       7'h7F
`define WWD_WIN_RST       7'h7F
`define WWD_CNT_EDGE      7'h40
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WWD_PRESCALE      12288
`endif

// ===== hdl/wwd_pkg.sv
// Types of the window watchdog
package wwd_pkg;
    typedef logic [6:0] wwd_count_t;
    typedef enum logic [1:0] {WWD_IDLE, WWD_ACK} wwd_bus_st_t;
endpackage

// ===== hdl/wwd_prescaler.sv
// Free-running prescaler producing one tick per period
`include "wwd_regs.svh"
module wwd_prescaler (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Tick
    output logic      tick_o
);
    import wwd_pkg::*;
    localparam int unsigned PERIOD = `WWD_PRESCALE;
    localparam logic [13:0] LAST   = 14'(PERIOD - 1);

    logic [13:0] cnt_q;
    logic [13:0] cnt_d;

    // Phase never disturbed by register writes
    always_comb begin
        cnt_d = (cnt_q == LAST) ? 14'h0000 : cnt_q + 14'h0001;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 14'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick_o = (cnt_q == LAST);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_tick_single;
        @(posedge clk_i) disable iff (rst_i) tick_o |=> !tick_o [*8];
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick too dense");
endmodule

// ===== hdl/wwd_top.sv
// Window watchdog with Wishbone classic register slave
`include "wwd_regs.svh"
module wwd_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Options and halt
    input  wire logic        hw_watchdog_i,
    input  wire logic        halt_reset_option_i,
    input  wire logic        halt_req_i,
    // Reset request and live count
    output logic             sys_reset_req_o,
    output wwd_pkg::wwd_count_t count_o
);
    import wwd_pkg::*;

    logic        tick;
    logic        activation_bit_q, activation_bit_d;
    wwd_count_t  cnt_q, cnt_d;
    wwd_count_t  win_q, win_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        rst_req_q, rst_req_d;
    logic        hw_s1_q, hw_s2_q, ho_s1_q, ho_s2_q, hr_s1_q, hr_s2_q;
    logic        active;
    logic        req;
    logic        wr_ctrl;
    logic        wr_win;

    wwd_prescaler u_pre (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hw_s1_q <= 1'b0;
            hw_s2_q <= 1'b0;
            ho_s1_q <= 1'b0;
            ho_s2_q <= 1'b0;
            hr_s1_q <= 1'b0;
            hr_s2_q <= 1'b0;
        end else begin
            hw_s1_q <= hw_watchdog_i;
            hw_s2_q <= hw_s1_q;
            ho_s1_q <= halt_reset_option_i;
            ho_s2_q <= ho_s1_q;
            hr_s1_q <= halt_req_i;
            hr_s2_q <= hr_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    // Ack one cycle after request, dropped the next cycle
    assign req     = cyc_i && stb_i && !ack_q;
    assign wr_ctrl = req && we_i && sel_i[0] && (adr_i == `WWD_CTRL_ADDR);
    assign wr_win  = req && we_i && sel_i[0] && (adr_i == `WWD_WIN_ADDR);
    assign active  = activation_bit_q || hw_s2_q;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        activation_bit_d = activation_bit_q;
        cnt_d            = cnt_q;
        win_d            = win_q;
        rst_req_d        = 1'b0;
        ack_d            = req;
        rdat_d           = 32'h0000_0000;
        if (wr_ctrl && dat_i[`WWD_ACT_BIT]) begin
            activation_bit_d = 1'b1;
        end
        if (tick) begin
            cnt_d = cnt_q - 7'h01;
        end
        if (wr_ctrl) begin
            cnt_d = dat_i[6:0];
        end
        if (wr_win) begin
            win_d = dat_i[6:0];
        end
        if (active && tick && !wr_ctrl && cnt_q == `WWD_CNT_EDGE) begin
            rst_req_d = 1'b1;
        end
        if (active && wr_ctrl && cnt_q > win_q) begin
            rst_req_d = 1'b1;
        end
        if (active && ho_s2_q && hr_s2_q) begin
            rst_req_d = 1'b1;
        end
        if (req && !we_i) begin
            if (adr_i == `WWD_CTRL_ADDR) begin
                rdat_d = {24'h00_0000, activation_bit_q, cnt_q};
            end else if (adr_i == `WWD_WIN_ADDR) begin
                rdat_d = {24'h00_0000, 1'b0, win_q};
            end
        end
        if (!active) begin
            rst_req_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            activation_bit_q <= 1'b0;
            cnt_q            <= `WWD_CNT_RST;
            win_q            <= `WWD_WIN_RST;
            ack_q            <= 1'b0;
            rdat_q           <= 32'h0000_0000;
            rst_req_q        <= 1'b0;
        end else begin
            activation_bit_q <= activation_bit_d;
            cnt_q            <= cnt_d;
            win_q            <= win_d;
            ack_q            <= ack_d;
            rdat_q           <= rdat_d;
            rst_req_q        <= rst_req_d;
        end
    end

    assign ack_o           = ack_q;
    assign dat_o           = rdat_q;
    assign sys_reset_req_o = rst_req_q;
    assign count_o         = cnt_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_act_sticky;
        @(posedge clk_i) disable iff (rst_i) activation_bit_q |=> activation_bit_q;
    endproperty
    a_act_sticky: assert property (p_act_sticky) else $error("activation cleared");

    property p_no_req_idle;
        @(posedge clk_i) disable iff (rst_i) !$past(active) |-> !sys_reset_req_o;
    endproperty
    a_no_req_idle: assert property (p_no_req_idle) else $error("request while idle");

    property p_read_ctrl;
        @(posedge clk_i) disable iff (rst_i)
            (req && !we_i && adr_i == `WWD_CTRL_ADDR) |=> dat_o[6:0] == $past(cnt_q);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("bad count read");

    property p_dec;
        @(posedge clk_i) disable iff (rst_i)
            (tick && !wr_ctrl) |=> cnt_q == $past(cnt_q) - 7'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement");

    property p_edge;
        @(posedge clk_i) disable iff (rst_i)
            (active && tick && !wr_ctrl && cnt_q == 7'h40) |=> sys_reset_req_o && cnt_q == 7'h3F;
    endproperty
    a_edge: assert property (p_edge) else $error("missed edge reset");

    property p_hw;
        @(posedge clk_i) disable iff (rst_i)
            (hw_s2_q && wr_ctrl && cnt_q > win_q) |=> sys_reset_req_o;
    endproperty
    a_hw: assert property (p_hw) else $error("hw option ignored");

    property p_win_rd;
        @(posedge clk_i) disable iff (rst_i)
            (req && !we_i && adr_i == `WWD_WIN_ADDR) |=>
            dat_o[7] == 1'b0 && dat_o[6:0] == $past(win_q);
    endproperty
    a_win_rd: assert property (p_win_rd) else $error("bad window read");

    property p_rst_val;
        @(posedge clk_i) $past(rst_i) |-> cnt_q == 7'h7F && win_q == 7'h7F && !activation_bit_q;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("bad reset value");

    property p_early;
        @(posedge clk_i) disable iff (rst_i)
            (active && wr_ctrl && cnt_q > win_q) |=> sys_reset_req_o;
    endproperty
    a_early: assert property (p_early) else $error("early reload missed");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i) (active && ho_s2_q && hr_s2_q) |=> sys_reset_req_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt reset missed");

    property p_set_act;
        @(posedge clk_i) disable iff (rst_i) (wr_ctrl && dat_i[`WWD_ACT_BIT]) |=> activation_bit_q;
    endproperty
    a_set_act: assert property (p_set_act) else $error("activation not set");

    property p_free_run;
        @(posedge clk_i) disable iff (rst_i)
            (!active && tick && !wr_ctrl) |=> cnt_q == $past(cnt_q) - 7'h01;
    endproperty
    a_free_run: assert property (p_free_run) else $error("count stalled");

    // ---------------------------------------------------------------
    // Bus checks
    // ---------------------------------------------------------------
    // Master relies on a single-cycle answer
    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i) req |=> ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack missing");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

    property p_hi_zero;
        @(posedge clk_i) disable iff (rst_i) dat_o[31:8] == 24'h00_0000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
endmodule

// ===== verif/window_watchdog_regs_tb_top.sv
// Self-checking bench of the window watchdog
module window_watchdog_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wwd_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd;
    logic        ack;
    logic        req;
    logic        hw = 1'b0;
    logic        hopt = 1'b0;
    logic        halt = 1'b0;
    wwd_count_t  cnt;
    int          failures = 0;
    int          num_checks = 0;
    int          reqs = 0;
    int          seed = 9;
    int          r;
    int          v;
    int          m_pre = 0;
    int          m_cnt = 127;
    bit          m_on = 1'b0;
    wwd_top dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack),
        .hw_watchdog_i(hw), .halt_reset_option_i(hopt), .halt_req_i(halt),
        .sys_reset_req_o(req), .count_o(cnt));
    always #2 clk = ~clk;
    // Model side: every clock cycle with reset request high counted
    always @(posedge clk) if (req === 1'b1) reqs <= reqs + 1;
    // Model of the live count: free prescaler, write wins over tick
    always @(posedge clk) begin
        if (m_on) begin
            chk(32'(cnt), 32'(m_cnt));
        end
        if (rst === 1'b1) begin
            m_pre = 0;
            m_cnt = 127;
            m_on = 1'b1;
        end else begin
            if (cyc && stb && we && sel[0] && adr == 8'h00 && ack !== 1'b1) begin
                m_cnt = wd & 127;
            end else if (m_pre == 12287) begin
                m_cnt = (m_cnt + 127) & 127;
            end
            m_pre = (m_pre == 12287) ? 0 : m_pre + 1;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_in(input logic [31:0] g, input int lo, input int hi);
        num_checks++;
        if ($isunknown(g) || !(g >= lo && g <= hi)) begin
            failures++;
            $display("BAD %0t got %h out of range", $time, g);
        end
    endtask
    // Request held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            failures++;
            $display("BAD %0t no ack", $time);
            tally_and_finish();
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        wait_n(8);
        rst <= 1'b0;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        do_reset();
        xfer(0, 8'h00, 0, q);
        chk(q, 32'h7F);
        xfer(0, 8'h04, 0, q);
        chk(q, 32'h7F);
        xfer(0, 8'h08, 0, q);
        chk(q, 32'h0);
        xfer(1, 8'h04, 32'hFF, q);
        sel <= 4'h0;
        xfer(1, 8'h04, 32'h55, q);
        sel <= 4'hF;
        xfer(0, 8'h04, 0, q);
        chk(q, 32'h7F);
        $display("test 1 done");
        // Steps across 0x40 while disabled: counts on, no request
        r = reqs;
        v = 32'h40 | ($random(seed) & 32'h1);
        xfer(1, 8'h00, v, q);
        xfer(0, 8'h00, 0, q);
        chk(q, v);
        wait_n(12288);
        xfer(0, 8'h00, 0, q);
        chk_in(q, v - 2, v - 1);
        xfer(1, 8'h04, 32'h10, q);
        xfer(1, 8'h00, 32'h7F, q);
        wait_n(3);
        chk(32'(reqs - r), 0);
        xfer(1, 8'h04, 32'h7F, q);
        $display("test 2 done");
        xfer(1, 8'h00, 32'hC1, q);
        xfer(1, 8'h00, 32'h41, q);
        xfer(0, 8'h00, 0, q);
        chk(q, 32'hC1);
        wait_n(2 * 12288 + 8);
        chk(32'(reqs - r), 1);
        $display("test 3 done");
        xfer(1, 8'h00, 32'hFF, q);
        xfer(1, 8'h04, 32'h50, q);
        r = reqs;
        xfer(1, 8'h00, 32'hC5, q);
        wait_n(3);
        chk(32'(reqs - r), 1);
        do_reset();
        xfer(0, 8'h00, 0, q);
        chk(q, 32'h7F);
        $display("test 4 done");
        hw <= 1'b1;
        xfer(1, 8'h04, 32'h50, q);
        r = reqs;
        xfer(1, 8'h00, 32'h7F, q);
        wait_n(3);
        chk(32'(reqs - r), 1);
        hw <= 1'b0;
        wait_n(4);
        r = reqs;
        xfer(1, 8'h00, 32'h7F, q);
        hopt <= 1'b1;
        halt <= 1'b1;
        wait_n(6);
        chk(32'(reqs - r), 0);
        xfer(1, 8'h04, 32'h7F, q);
        xfer(1, 8'h00, 32'hFF, q);
        wait_n(6);
        chk(32'(reqs > r), 1);
        hopt <= 1'b0;
        wait_n(5);
        r = reqs;
        wait_n(6);
        chk(32'(reqs - r), 0);
        $display("test 5 done");
        tally_and_finish();
    end
endmodule
